// ### design/pic_top.v
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_top (
   // system
   input  wire        CLK,
   input  wire        RST_N,
   // wishbone slave
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   // request sources
   input  wire [39:0] EVT_IN,
   input  wire        SOFT_TRAP,
   // cpu side
   output wire        INT_REQ,
   output reg  [19:0] INT_VECTOR,
   output reg  [5:0]  INT_ID,
   input  wire        INT_ACK,
   input  wire        RET_MASKABLE,
   input  wire        RET_NMI,
   input  wire        RET_GATE,
   output reg         SAVED_GATE,
   // system events
   output reg         WDT_RST_REQ,
   output wire        IRQ
);

   // expand byte selects to a bit mask
   function [31:0] pic_wmask;
      input [3:0] sel;
      begin
         pic_wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   // lowest slot number wins; zero means nothing eligible
   function [5:0] pic_pick;
      input [39:0] req;
      integer i;
      begin
         pic_pick = 6'h00;
         for (i = `PIC_NSRC - 1; i > 0; i = i - 1) begin
            if (req[i]) begin
               pic_pick = i[5:0];
            end
         end
      end
   endfunction

   // slot number to vector address
   function [19:0] pic_vec;
      input [5:0] id;
      begin
         if (id == `PIC_SLOT_SWI) begin
            pic_vec = `PIC_VEC_SWI;
         end else if (id == `PIC_SLOT_WDT) begin
            pic_vec = `PIC_VEC_WDT; // see RULE9
         end else if (id >= `PIC_SLOT_PIN0 && id <= `PIC_SLOT_LAST_LO) begin
            pic_vec = `PIC_VEC_LO_BASE - {12'h000, id - 6'h03, 2'h0}; // see RULE11
         end else if (id >= `PIC_SLOT_FIRST_HI) begin
            pic_vec = `PIC_VEC_HI_BASE - {12'h000, id - 6'h20, 2'h0}; // see RULE11
         end else begin
            pic_vec = `PIC_VEC_NONE;
         end
      end
   endfunction

   // full-width copies of packed constants so that single bits can be selected
   localparam [1:0]  CTRL_RST = `PIC_CTRL_RST;
   localparam [39:0] EF_MASK  = `PIC_EF_MASK;

   reg  [39:0] sync1;
   reg  [39:0] sync2;
   reg  [39:0] sync3;
   reg  [39:0] pend;
   reg  [39:0] ef;
   reg         gate;
   reg         pin0_request_gate;
   reg         wdt_action_select;
   reg  [1:0]  stat;
   reg  [1:0]  mask;
   reg  [3:0]  nest;
   reg         valid;
   reg         ack_d;
   reg  [39:0] next_pend;
   reg  [39:0] elig;
   reg  [39:0] occ;
   reg  [39:0] sw_clr;
   wire [31:0] wm;
   wire        wr;
   wire        accept;
   wire        wdt_occ;
   wire [5:0]  win;
   integer     k;

   assign wm      = pic_wmask(WB_SEL_I) & ~WB_DAT_I;
   assign wr      = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
   assign accept  = INT_ACK & INT_REQ;
   assign wdt_occ = sync2[`PIC_SLOT_WDT] & ~sync3[`PIC_SLOT_WDT];
   assign win     = pic_pick(elig); // see RULE6
   // second accept blocked until the cleared latch is seen by the encoder
   assign INT_REQ = valid & ~ack_d; // see RULE4
   assign IRQ     = |(stat & mask);

   // two-stage synchroniser plus edge memory; sync1 feeds only sync2
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1 <= 40'h00_0000_0000;
         sync2 <= 40'h00_0000_0000;
         sync3 <= 40'h00_0000_0000;
      end else begin
         sync1 <= EVT_IN;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // occurrences, eligibility and software clears
   always @* begin
      occ = sync2 & ~sync3 & `PIC_SRC_MASK; // see RULE17
      occ[`PIC_SLOT_SWI] = SOFT_TRAP;
      // in reset-request mode the watchdog never reaches its latch
      occ[`PIC_SLOT_WDT] = wdt_occ & ~wdt_action_select; // see RULE12
      elig = 40'h00_0000_0000;
      for (k = 1; k < `PIC_NSRC; k = k + 1) begin
         if (k == `PIC_SLOT_SWI || k == `PIC_SLOT_WDT) begin
            // pseudo non-maskable, no mutual order imposed beyond slot number
            elig[k] = pend[k]; // see RULE2 see RULE16 see RULE7
         end else if (k == `PIC_SLOT_PIN0) begin
            elig[k] = pend[k] & gate & ef[k] & pin0_request_gate; // see RULE10
         end else begin
            elig[k] = pend[k] & gate & ef[k]; // see RULE5 see RULE8
         end
      end
      sw_clr = 40'h00_0000_0000;
      if (wr && WB_ADR_I == `PIC_ADR_PEND_LO) begin
         sw_clr[31:0] = wm; // see RULE15
      end
      if (wr && WB_ADR_I == `PIC_ADR_PEND_HI) begin
         sw_clr[39:32] = wm[7:0];
      end
      next_pend = pend & ~sw_clr;
      if (accept) begin
         next_pend[INT_ID] = 1'b0; // see RULE13
      end
      // a new occurrence beats any clear in the same cycle
      next_pend = (next_pend | occ) & `PIC_EF_MASK | (next_pend | occ) & 40'h00_0000_0006; // see RULE3 see RULE4
   end

   // pending latches
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend <= 40'h00_0000_0000;
      end else begin
         pend <= next_pend;
      end
   end

   // winner and vector, refreshed every cycle
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         valid      <= 1'b0;
         INT_ID     <= 6'h00;
         INT_VECTOR <= `PIC_VEC_NONE;
         ack_d      <= 1'b0;
      end else begin
         valid      <= (win != 6'h00); // see RULE18
         INT_ID     <= win; // see RULE1
         INT_VECTOR <= pic_vec(win); // see RULE18
         ack_d      <= accept;
      end
   end

   // global gate: acceptance beats returns, returns beat software
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gate       <= 1'b0;
         SAVED_GATE <= 1'b0;
      end else begin
         if (accept) begin
            SAVED_GATE <= gate; // see RULE14
            gate       <= 1'b0; // see RULE14
         end else if (RET_MASKABLE) begin
            gate <= 1'b1; // see RULE14
         end else if (RET_NMI) begin
            gate <= RET_GATE;
         end else if (wr && WB_ADR_I == `PIC_ADR_EN_LO && WB_SEL_I[0]) begin
            gate <= WB_DAT_I[`PIC_EN_GATE_BIT];
         end
      end
   end

   // accept bits, control and mask registers
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ef                <= 40'h00_0000_0000;
         pin0_request_gate <= 1'b0;
         wdt_action_select <= CTRL_RST[`PIC_CTRL_WSEL_BIT];
         mask              <= 2'h0;
      end else begin
         if (wr && WB_ADR_I == `PIC_ADR_EN_LO) begin
            ef[31:0] <= (ef[31:0] & ~pic_wmask(WB_SEL_I) | WB_DAT_I & pic_wmask(WB_SEL_I))
                        & EF_MASK[31:0];
         end
         if (wr && WB_ADR_I == `PIC_ADR_EN_HI && WB_SEL_I[0]) begin
            ef[39:32] <= WB_DAT_I[7:0];
         end
         if (wr && WB_ADR_I == `PIC_ADR_CTRL && WB_SEL_I[0]) begin
            pin0_request_gate <= WB_DAT_I[`PIC_CTRL_PIN0_BIT];
            wdt_action_select <= WB_DAT_I[`PIC_CTRL_WSEL_BIT];
         end
         if (wr && WB_ADR_I == `PIC_ADR_MASK && WB_SEL_I[0]) begin
            mask <= WB_DAT_I[1:0];
         end
      end
   end

   // sticky status, write one to clear, setting wins
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stat        <= 2'h0;
         WDT_RST_REQ <= 1'b0;
      end else begin
         WDT_RST_REQ <= wdt_occ & wdt_action_select;
         stat <= (stat & ~((wr && WB_ADR_I == `PIC_ADR_STAT && WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'h0))
                 | {wdt_occ & wdt_action_select, accept};
      end
   end

   // nesting depth: up on accept, down on either return, saturating
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         nest <= 4'h0;
      end else if (accept && !(RET_MASKABLE || RET_NMI)) begin
         if (nest != `PIC_NEST_MAX) begin
            nest <= nest + 4'h1; // see RULE8
         end
      end else if (!accept && (RET_MASKABLE || RET_NMI) && nest != 4'h0) begin
         nest <= nest - 4'h1;
      end
   end

   // wishbone answer: ack one cycle after the strobe, read data registered
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
         case (WB_ADR_I)
            `PIC_ADR_PEND_LO: WB_DAT_O <= {pend[31:1], 1'b0};
            `PIC_ADR_PEND_HI: WB_DAT_O <= {24'h000000, pend[39:32]};
            `PIC_ADR_EN_LO:   WB_DAT_O <= {ef[31:3], 2'h0, gate};
            `PIC_ADR_EN_HI:   WB_DAT_O <= {24'h000000, ef[39:32]};
            `PIC_ADR_CTRL:    WB_DAT_O <= {30'h00000000, wdt_action_select, pin0_request_gate};
            `PIC_ADR_STAT:    WB_DAT_O <= {30'h00000000, stat};
            `PIC_ADR_MASK:    WB_DAT_O <= {30'h00000000, mask};
            `PIC_ADR_NEST:    WB_DAT_O <= {28'h0000000, nest};
            `PIC_ADR_VECT:    WB_DAT_O <= {4'h0, valid, INT_ID, 1'b0, INT_VECTOR};
            default:          WB_DAT_O <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// ### design/pic_consts.vh
// Behaviour
// RULE1: thirty-six sources plus reset, each own slot.
// RULE2: soft trap and watchdog pseudo non-maskable.
// RULE3: every source has latch and own vector.
// RULE4: request sets latch, latch asks CPU.
// RULE5: maskable needs global gate and source bit.
// RULE6: simultaneous requests taken lowest number first.
// RULE7: no ordering among non-maskable sources themselves.
// RULE8: nesting allowed when gating permits higher request.
// RULE9: watchdog slot 2, latch 2, vector FFFF4.
// RULE10: pin 0 needs gate, bit 3, pin gate.
// RULE11: vectors step down four per priority; code jumps from FFF80 at slot 31 to FFF3C at slot 32.
// RULE12: software clears action select for watchdog interrupt.
// RULE13: acceptance clears that source's latch at once.
// RULE14: accept stacks gate, clears it; return sets.
// RULE15: software may only clear latches, never set.
// RULE16: pseudo non-maskable ignore gate and source bits.
// RULE17: reserved slots have no request input.
// RULE18: present best eligible vector every cycle.
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
// register byte addresses
`define PIC_ADR_PEND_LO   8'h00
`define PIC_ADR_PEND_HI   8'h04
`define PIC_ADR_EN_LO     8'h08
`define PIC_ADR_EN_HI     8'h0C
`define PIC_ADR_CTRL      8'h10
`define PIC_ADR_STAT      8'h14
`define PIC_ADR_MASK      8'h18
`define PIC_ADR_NEST      8'h1C
`define PIC_ADR_VECT      8'h20
// slot layout
`define PIC_NSRC          40
`define PIC_SLOT_SWI      1
`define PIC_SLOT_WDT      2
`define PIC_SLOT_PIN0     3
`define PIC_SLOT_LAST_LO  31
`define PIC_SLOT_FIRST_HI 32
`define PIC_HI_W          8
// slots with a request input: 2,3,5,6,8-13,15-39 (0,1,4,7,14 none)
`define PIC_SRC_MASK      40'hFF_FFFF_BF6C
// maskable slots with an accept bit
`define PIC_EF_MASK       40'hFF_FFFF_FFF8
// field positions
`define PIC_EN_GATE_BIT   0
`define PIC_CTRL_PIN0_BIT 0
`define PIC_CTRL_WSEL_BIT 1
`define PIC_STAT_ACC_BIT  0
`define PIC_STAT_WDR_BIT  1
`define PIC_STAT_W        2
// reset values and nesting limit
`define PIC_CTRL_RST      2'h2
`define PIC_NEST_MAX      4'hF
// vectors
`define PIC_VEC_SWI       20'hFFFF8
`define PIC_VEC_WDT       20'hFFFF4
`define PIC_VEC_LO_BASE   20'hFFFF0
`define PIC_VEC_HI_BASE   20'hFFF3C
`define PIC_VEC_NONE      20'hFFFFC
`endif

// ### dv/pic_top_asserts.sv
`timescale 1ns/1ps
module pic_chk (
   // system
   input wire        CLK,
   input wire        RST_N,
   // register bus
   input wire        WB_CYC_I,
   input wire        WB_STB_I,
   input wire        WB_ACK_O,
   // cpu side
   input wire        INT_REQ,
   input wire        INT_ACK,
   input wire [5:0]  INT_ID,
   input wire [19:0] INT_VECTOR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // bus answers in the next cycle, for one cycle only
   property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("bus request not acked");
   property p_ack1; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack1: assert property (p_ack1) else $error("ack longer than a cycle");
   // an accepted request leaves one idle cycle while its latch clears
   property p_gap; INT_ACK && INT_REQ |=> !INT_REQ; endproperty
   a_gap: assert property (p_gap) else $error("request stays after accept");
   // no bus traffic and no accept: the pending request must stay
   property p_hold; INT_REQ && !INT_ACK && !WB_CYC_I |=> INT_REQ; endproperty
   a_hold: assert property (p_hold) else $error("request lost");
   // vector table, two linear runs plus the watchdog slot
   property p_vec; INT_REQ && INT_ID > 6'h2 && INT_ID < 6'h20 |-> INT_VECTOR == 20'hFFFF0 - 4 * (INT_ID - 3); endproperty
   a_vec: assert property (p_vec) else $error("low vector wrong");
   property p_vhi; INT_REQ && INT_ID > 6'h1F |-> INT_VECTOR == 20'hFFF3C - 4 * (INT_ID - 32); endproperty
   a_vhi: assert property (p_vhi) else $error("high vector wrong");
   property p_wdt; INT_REQ && INT_ID == 6'h2 |-> INT_VECTOR == 20'hFFFF4; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog vector wrong");
   // unconnected slots can never be presented
   property p_rsv; INT_REQ |-> !(INT_ID inside {6'h0, 6'h4, 6'h7, 6'hE}); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved slot presented");
endmodule
bind pic_top pic_chk u_chk (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_ACK_O(WB_ACK_O), .INT_REQ(INT_REQ), .INT_ACK(INT_ACK), .INT_ID(INT_ID), .INT_VECTOR(INT_VECTOR));

// ### dv/pic_cpu_model.sv
`timescale 1ns/1ps
module pic_cpu_model (
   // system
   input wire       CLK,
   input wire       RST_N,
   // controller side
   input wire       INT_REQ,
   input wire [5:0] INT_ID,
   output reg       INT_ACK,
   // bench control and report
   input wire       take,
   input wire [2:0] lag,
   output reg [5:0] got,
   output reg       got_v
);
   reg [2:0] wait_cnt;
   // accept after lag cycles; ack drops after one cycle, so accepts stay two apart
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         INT_ACK  <= 1'b0;
         got_v    <= 1'b0;
         got      <= 6'h0;
         wait_cnt <= 3'h0;
      end else begin
         INT_ACK  <= take && INT_REQ && !INT_ACK && wait_cnt == lag;
         wait_cnt <= (take && INT_REQ && !INT_ACK && wait_cnt != lag) ? wait_cnt + 3'h1 : 3'h0;
         got_v    <= INT_ACK && INT_REQ;
         if (INT_ACK && INT_REQ) got <= INT_ID;
      end
   end
endmodule

// ### dv/pic_tb_top.sv
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_tb_top;
   reg         CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, SOFT_TRAP, RET_MASKABLE, take;
   reg  [7:0]  WB_ADR_I;
   reg  [31:0] WB_DAT_I, r;
   reg  [39:0] EVT_IN, pat;
   reg  [15:0] seed;
   reg  [2:0]  lag;
   wire [31:0] WB_DAT_O;
   wire        WB_ACK_O, INT_REQ, INT_ACK, IRQ, got_v, SAVED_GATE, WDT_RST_REQ;
   wire [19:0] INT_VECTOR;
   integer     exp_id;
   wire [5:0]  INT_ID, got;
   integer     n_fail, tests_run, i, k;
   integer     q[$];
   pic_top uut (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
      .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'hF), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
      .EVT_IN(EVT_IN), .SOFT_TRAP(SOFT_TRAP), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .INT_ID(INT_ID),
      .INT_ACK(INT_ACK), .RET_MASKABLE(RET_MASKABLE), .RET_NMI(1'b0), .RET_GATE(1'b0),
      .SAVED_GATE(SAVED_GATE), .WDT_RST_REQ(WDT_RST_REQ), .IRQ(IRQ));
   pic_cpu_model cpu (.CLK(CLK), .RST_N(RST_N), .INT_REQ(INT_REQ), .INT_ID(INT_ID), .INT_ACK(INT_ACK),
      .take(take), .lag(lag), .got(got), .got_v(got_v));
   function [15:0] lf(input [15:0] v);
      lf = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // vector table from the slot number: two linear runs plus the two fixed slots
   function [19:0] vexp(input integer id);
      vexp = (id == 1) ? 20'hFFFF8 : (id == 2) ? 20'hFFFF4 :
             (id < 32) ? 20'hFFFF0 - 4 * (id - 3) : 20'hFFF3C - 4 * (id - 32);
   endfunction
   task chk(input [39:0] a, input [39:0] e);
      begin
         tests_run = tests_run + 1;
         if (a !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
         end
      end
   endtask
   // one classic cycle; read data kept in r
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         WB_CYC_I <= 1'b1;
         WB_STB_I <= 1'b1;
         WB_WE_I  <= w;
         WB_ADR_I <= a;
         WB_DAT_I <= d;
         @(posedge CLK);
         while (WB_ACK_O !== 1'b1) @(posedge CLK);
         r = WB_DAT_O;
         WB_CYC_I <= 1'b0;
         WB_STB_I <= 1'b0;
         @(posedge CLK);
      end
   endtask
   task summarize;
      begin
         if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // clock and hang guard
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      #200000;
      n_fail = n_fail + 1;
      summarize;
   end
   // main sequence
   initial begin
      {RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, SOFT_TRAP, RET_MASKABLE, take} = 7'h0;
      WB_ADR_I = 8'h0;
      WB_DAT_I = 32'h0;
      EVT_IN = 40'h0;
      lag = 3'h0;
      seed = 16'h4B71;
      n_fail = 0;
      tests_run = 0;
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      wb(1'b0, `PIC_ADR_CTRL, 32'h0);
      chk(r, 40'h2);
      // watchdog in reset-request mode: reset pulse, latch 2 stays clear
      EVT_IN <= 40'h4;
      repeat (4) @(posedge CLK);
      chk(WDT_RST_REQ, 40'h1);
      EVT_IN <= 40'h0;
      wb(1'b0, `PIC_ADR_PEND_LO, 32'h0);
      chk(r, 40'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk(r, 40'h0);
      wb(1'b1, `PIC_ADR_CTRL, 32'h1);
      for (i = 0; i < 4; i = i + 1) begin
         seed = lf(lf(lf(seed)));
         pat = {seed[7:0], seed, seed ^ 16'h5A3C} & (`PIC_SRC_MASK | 40'h2);
         lag <= seed[2:0];
         EVT_IN <= pat;
         SOFT_TRAP <= pat[1];
         @(posedge CLK);
         SOFT_TRAP <= 1'b0;
         @(posedge CLK);
         EVT_IN <= 40'h0;
         repeat (5) @(posedge CLK);
         chk(INT_REQ, pat[1] | pat[2]);
         wb(1'b1, `PIC_ADR_PEND_LO, 32'hFFFFFFFF);
         if (i == 3) wb(1'b1, `PIC_ADR_PEND_HI, 32'h0);
         if (i == 3) pat[39:32] = 8'h0;
         wb(1'b0, `PIC_ADR_PEND_LO, 32'h0);
         chk(r, pat[31:0]);
         wb(1'b0, `PIC_ADR_PEND_HI, 32'h0);
         chk(r, pat[39:32]);
         for (k = 39; k >= 0; k = k - 1) if (pat[k]) q.push_front(k);
         wb(1'b1, `PIC_ADR_EN_HI, 32'hFF);
         wb(1'b1, `PIC_ADR_EN_LO, 32'hFFFFFFFF);
         take <= 1'b1;
         // one return per accept reopens the gate for the next winner
         while (q.size() > 0) begin
            for (k = 0; k < 100 && got_v !== 1'b1; k = k + 1) @(posedge CLK);
            exp_id = q.pop_front();
            chk(got, exp_id);
            chk(INT_VECTOR, vexp(exp_id));
            chk(SAVED_GATE, 40'h1);
            RET_MASKABLE <= 1'b1;
            @(posedge CLK);
            RET_MASKABLE <= 1'b0;
         end
         take <= 1'b0;
         wb(1'b1, `PIC_ADR_EN_LO, 32'h0);
         wb(1'b0, `PIC_ADR_PEND_LO, 32'h0);
         chk(r, 40'h0);
      end
      wb(1'b1, `PIC_ADR_MASK, 32'h1);
      chk(IRQ, 40'h1);
      wb(1'b1, `PIC_ADR_STAT, 32'h3);
      chk(IRQ, 40'h0);
      summarize;
   end
endmodule
